/* hdl/lpm_ctrl.sv */
// lpm_ctrl: power-mode controller (idle, stop, suspend) and its wake logic
// assumes the core pulses instr_done once the setting instruction completes
// Contract
// - three modes: idle, stop, suspend
// - idle bit halts core after instruction
// - idle keeps registers, clocks, peripherals running
// - interrupt ends idle, clears bit, resumes
// - reset exits any mode, fetch 0x0000
// - follow idle write with two-byte instruction
// - watchdog runs in idle, resets on expiry
// - stop bit halts oscillator, core, peripherals
// - only reset leaves stop
// - missing-clock timeout resets out of stop
// - suspend bit halts core and oscillator
// - suspend keeps port match, timer 3 only
// - divider set to divide-by-1 before suspend
// - five events end suspend
// - timer 3 clocked external/8 for suspend
// - non-reset wake resumes at next instruction
// - pre-entry pending events do not wake
// - port match wake is level sensitive
// - idle and stop bits read zero
`timescale 1ns/1ps
module lpm_ctrl #(
   parameter int unsigned WDT_CYCLES = lpm_pkg::WDT_CYCLES_DEF  // watchdog expiry
) (
   input  wire logic      clk_i,          // system clock
   input  wire logic      rst_n_i,        // async reset, active low
   lpm_if.dev             bus,            // link to the core side
   input  wire logic      ext_rst_i,      // external reset request
   input  wire logic      wdt_kick_i,     // watchdog restart pulse
   input  wire logic      port_match_i,   // port match level
   input  wire logic      t3_ovf_i,       // timer 3 overflow pulse
   input  wire logic      cmp_low_i,      // comparator output low level
   input  wire logic      cs_gt_i,        // capacitive sense greater-than pulse
   output logic           hfosc_run_o,    // internal oscillator running
   output logic           dig_clk_en_o,   // digital peripheral clock enable
   output logic           port_match_en_o,// port match logic active
   output logic           t3_run_o        // timer 3 active
);

   // ****************************************
   // state and registers
   // ****************************************
   lpm_pkg::lpm_mode_t state_reg;
   logic [7:0]  gf_reg;
   logic [7:0]  osc_reg;
   logic        idle_pend_reg;
   logic        stop_pend_reg;
   logic        susp_pend_reg;
   logic [31:0] wdt_cnt_reg;
   logic [31:0] mcd_cnt_reg;
   logic        wdt_fire;
   logic        mcd_fire;
   logic        any_rst;
   logic        susp_wake;
   logic        idle_wake;

   assign wdt_fire  = bus.wdt_en && (state_reg != lpm_pkg::LPM_MODE_STOP)
                      && (state_reg != lpm_pkg::LPM_MODE_SUSP)
                      && (wdt_cnt_reg >= WDT_CYCLES - 1);
   assign mcd_fire  = bus.mcd_en && (state_reg == lpm_pkg::LPM_MODE_STOP)
                      && (mcd_cnt_reg >= lpm_pkg::MCD_CYCLES - 1);
   assign any_rst   = ext_rst_i || wdt_fire || mcd_fire;
   // edge sources only count while already suspended; port match is a level
   assign susp_wake = (state_reg == lpm_pkg::LPM_MODE_SUSP) &&
                      (port_match_i || t3_ovf_i || cs_gt_i ||
                       (bus.cmp_wake_en && cmp_low_i));
   assign idle_wake = (state_reg == lpm_pkg::LPM_MODE_IDLE) && bus.irq_req;

   // ****************************************
   // mode state machine
   // ****************************************
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= lpm_pkg::LPM_MODE_RUN;
      end else if (any_rst) begin
         state_reg <= lpm_pkg::LPM_MODE_RUN;
      end else begin
         case (state_reg)
            lpm_pkg::LPM_MODE_RUN: begin
               if (bus.instr_done && stop_pend_reg) begin
                  state_reg <= lpm_pkg::LPM_MODE_STOP;
               end else if (bus.instr_done && susp_pend_reg) begin
                  state_reg <= lpm_pkg::LPM_MODE_SUSP;
               end else if (bus.instr_done && idle_pend_reg) begin
                  state_reg <= lpm_pkg::LPM_MODE_IDLE;
               end
            end
            lpm_pkg::LPM_MODE_IDLE: begin
               if (idle_wake) begin
                  state_reg <= lpm_pkg::LPM_MODE_RUN;
               end
            end
            lpm_pkg::LPM_MODE_STOP: begin
               state_reg <= lpm_pkg::LPM_MODE_STOP;
            end
            lpm_pkg::LPM_MODE_SUSP: begin
               if (susp_wake) begin
                  state_reg <= lpm_pkg::LPM_MODE_RUN;
               end
            end
            default: begin
               state_reg <= lpm_pkg::LPM_MODE_RUN;
            end
         endcase
      end
   end

   // ****************************************
   // power control register
   // ****************************************
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gf_reg        <= lpm_pkg::POWER_CONTROL_REGISTER_RESET;
         idle_pend_reg <= 1'b0;
         stop_pend_reg <= 1'b0;
      end else if (any_rst) begin
         gf_reg        <= lpm_pkg::POWER_CONTROL_REGISTER_RESET;
         idle_pend_reg <= 1'b0;
         stop_pend_reg <= 1'b0;
      end else if (bus.power_control_register_wr) begin
         gf_reg        <= bus.wdata & lpm_pkg::POWER_CONTROL_REGISTER_GF_MASK;
         idle_pend_reg <= bus.wdata[lpm_pkg::POWER_CONTROL_REGISTER_IDLE_BIT];
         stop_pend_reg <= bus.wdata[lpm_pkg::POWER_CONTROL_REGISTER_STOP_BIT];
      end else if (bus.instr_done || idle_wake) begin
         // bits are consumed on entry and cleared on wake
         idle_pend_reg <= 1'b0;
         stop_pend_reg <= 1'b0;
      end
   end

   assign bus.power_control_register_rdata = gf_reg;

   // ****************************************
   // oscillator control register
   // ****************************************
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         osc_reg       <= lpm_pkg::OSC_RESET;
         susp_pend_reg <= 1'b0;
      end else if (any_rst) begin
         osc_reg       <= lpm_pkg::OSC_RESET;
         susp_pend_reg <= 1'b0;
      end else if (bus.osc_wr) begin
         osc_reg       <= bus.wdata;
         susp_pend_reg <= bus.wdata[lpm_pkg::OSC_SUSPEND_BIT];
      end else if (susp_wake) begin
         osc_reg[lpm_pkg::OSC_SUSPEND_BIT] <= 1'b0;
      end else if (bus.instr_done) begin
         susp_pend_reg <= 1'b0;
      end
   end

   assign bus.osc_rdata = osc_reg;

   // ****************************************
   // watchdog and missing-clock counters
   // ****************************************
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wdt_cnt_reg <= '0;
      end else if (any_rst || wdt_kick_i || !bus.wdt_en) begin
         wdt_cnt_reg <= '0;
      end else if (state_reg == lpm_pkg::LPM_MODE_RUN ||
                   state_reg == lpm_pkg::LPM_MODE_IDLE) begin
         wdt_cnt_reg <= wdt_cnt_reg + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mcd_cnt_reg <= '0;
      end else if (state_reg == lpm_pkg::LPM_MODE_STOP && bus.mcd_en) begin
         mcd_cnt_reg <= mcd_cnt_reg + 32'h0000_0001;
      end else begin
         mcd_cnt_reg <= '0;
      end
   end

   // ****************************************
   // outputs to the core and clock gates
   // ****************************************
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus.wake_irq     <= 1'b0;
         bus.resume       <= 1'b0;
         bus.restart      <= 1'b0;
         bus.restart_addr <= lpm_pkg::RESET_VECTOR;
      end else begin
         bus.wake_irq     <= idle_wake && !any_rst;
         bus.resume       <= susp_wake && !any_rst;
         bus.restart      <= any_rst;
         bus.restart_addr <= lpm_pkg::RESET_VECTOR;
      end
   end

   always_comb begin
      bus.mode     = state_reg;
      bus.cpu_halt = (state_reg != lpm_pkg::LPM_MODE_RUN);
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hfosc_run_o     <= 1'b1;
         dig_clk_en_o    <= 1'b1;
         port_match_en_o <= 1'b1;
         t3_run_o        <= 1'b1;
      end else begin
         case (state_reg)
            lpm_pkg::LPM_MODE_STOP: begin
               hfosc_run_o     <= 1'b0;
               dig_clk_en_o    <= 1'b0;
               port_match_en_o <= 1'b0;
               t3_run_o        <= 1'b0;
            end
            lpm_pkg::LPM_MODE_SUSP: begin
               hfosc_run_o     <= 1'b0;
               dig_clk_en_o    <= 1'b0;
               port_match_en_o <= 1'b1;
               t3_run_o        <= bus.t3_ext8;
            end
            default: begin
               hfosc_run_o     <= 1'b1;
               dig_clk_en_o    <= 1'b1;
               port_match_en_o <= 1'b1;
               t3_run_o        <= 1'b1;
            end
         endcase
      end
   end

endmodule // lpm_ctrl

/* hdl/lpm_pkg.sv */
// lpm_pkg: shared constants and types for the low-power mode controller pair
// assumes a single 10 MHz system clock shared by both ends
package lpm_pkg;

   // ****************************************
   // timing
   // ****************************************
   localparam int unsigned CLK_HZ          = 10_000_000;
   localparam int unsigned MCD_TIMEOUT_US  = 100;
   // longest time: rounds down
   localparam int unsigned MCD_CYCLES      = (MCD_TIMEOUT_US * (CLK_HZ / 1_000_000));
   localparam int unsigned WDT_CYCLES_DEF  = 4000;
   localparam int unsigned SET_GAP_CYCLES  = 2;

   // ****************************************
   // power control register layout
   // ****************************************
   localparam int unsigned POWER_CONTROL_REGISTER_IDLE_BIT   = 0;
   localparam int unsigned POWER_CONTROL_REGISTER_STOP_BIT   = 1;
   localparam logic [7:0]  POWER_CONTROL_REGISTER_RESET      = 8'h00;
   localparam logic [7:0]  POWER_CONTROL_REGISTER_GF_MASK    = 8'hFC;

   // ****************************************
   // oscillator control register layout
   // ****************************************
   localparam int unsigned OSC_SUSPEND_BIT = 5;
   localparam logic [7:0]  OSC_RESET       = 8'h00;

   // ****************************************
   // clock divider, restart address
   // ****************************************
   localparam logic [2:0]  SYSTEM_CLOCK_DIVIDER_FIELD_DIV1     = 3'h0;
   localparam logic [15:0] RESET_VECTOR    = 16'h0000;

   // ****************************************
   // controller register map (plain port)
   // ****************************************
   localparam logic [3:0]  CMD_OFS         = 4'h0;
   localparam logic [3:0]  CFG_OFS         = 4'h4;
   localparam logic [3:0]  STAT_OFS        = 4'h8;
   localparam int unsigned CMD_IDLE_BIT    = 0;
   localparam int unsigned CMD_STOP_BIT    = 1;
   localparam int unsigned CMD_SUSP_BIT    = 2;
   localparam int unsigned CFG_WDT_BIT     = 0;
   localparam int unsigned CFG_MCD_BIT     = 1;
   localparam int unsigned CFG_CMP_BIT     = 2;
   localparam int unsigned CFG_T3X8_BIT    = 3;
   localparam int unsigned CFG_DIV_LSB     = 4;
   localparam logic [7:0]  CFG_RESET       = 8'h00;

   typedef enum logic [1:0] {
      LPM_MODE_RUN,
      LPM_MODE_IDLE,
      LPM_MODE_STOP,
      LPM_MODE_SUSP
   } lpm_mode_t;

endpackage

/* hdl/lpm_if.sv */
// lpm_if: link between the power-mode controller and the processor core side
// assumes both ends share clk_i and rst_n_i
`timescale 1ns/1ps
interface lpm_if;
   logic                  power_control_register_wr;       // core writes power control register
   logic                  osc_wr;        // core writes oscillator control register
   logic [7:0]            wdata;         // write data for either register
   logic                  instr_done;    // setting instruction has completed
   logic [7:0]            power_control_register_rdata;    // power control read-back
   logic [7:0]            osc_rdata;     // oscillator control read-back
   logic [2:0]            system_clock_divider_field;        // system clock divider field
   logic                  wdt_en;        // watchdog enabled
   logic                  mcd_en;        // missing-clock detector enabled
   logic                  cmp_wake_en;   // comparator-low wake enabled
   logic                  t3_ext8;       // timer 3 clocked from external / 8
   logic                  irq_req;       // enabled interrupt pending
   logic                  cpu_halt;      // processor halted
   logic                  wake_irq;      // pulse: resumed, service interrupt
   logic                  resume;        // pulse: resumed at next instruction
   logic                  restart;       // pulse: reset sequence, fetch vector
   logic [15:0]           restart_addr;  // fetch address after restart
   lpm_pkg::lpm_mode_t    mode;          // current power mode

   modport dev (
      input  power_control_register_wr, osc_wr, wdata, instr_done, system_clock_divider_field, wdt_en, mcd_en,
             cmp_wake_en, t3_ext8, irq_req,
      output power_control_register_rdata, osc_rdata, cpu_halt, wake_irq, resume, restart,
             restart_addr, mode
   );
   modport core (
      output power_control_register_wr, osc_wr, wdata, instr_done, system_clock_divider_field, wdt_en, mcd_en,
             cmp_wake_en, t3_ext8, irq_req,
      input  power_control_register_rdata, osc_rdata, cpu_halt, wake_irq, resume, restart,
             restart_addr, mode
   );
endinterface

/* hdl/lpm_core.sv */
// lpm_core: core-side end; takes orders over a plain register port and drives
// the power-mode link; assumes software port timing: read data one cycle later
`timescale 1ns/1ps
module lpm_core (
   input  wire logic        clk_i,      // system clock
   input  wire logic        rst_n_i,    // async reset, active low
   lpm_if.core              bus,        // link to the controller
   input  wire logic [3:0]  addr_i,     // register byte address
   input  wire logic [7:0]  wdata_i,    // write data
   input  wire logic        wr_i,       // write strobe
   input  wire logic        rd_i,       // read strobe
   output logic      [7:0]  rdata_o,    // read data, cycle after rd_i
   input  wire logic        irq_i,      // enabled interrupt pending
   output logic             busy_o      // a mode command is in progress
);

   // ****************************************
   // command sequencer
   // ****************************************
   typedef enum logic [1:0] {
      LPM_SEQ_IDLE,
      LPM_SEQ_GAP,
      LPM_SEQ_DONE
   } lpm_seq_t;

   lpm_seq_t    seq_reg;
   logic [7:0]  cfg_reg;
   logic [1:0]  gap_reg;
   logic        cmd_wr;
   logic        cmd_any;

   assign cmd_wr  = wr_i && (addr_i == lpm_pkg::CMD_OFS);
   assign cmd_any = wdata_i[lpm_pkg::CMD_IDLE_BIT] || wdata_i[lpm_pkg::CMD_STOP_BIT] ||
                    wdata_i[lpm_pkg::CMD_SUSP_BIT];

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_reg <= lpm_pkg::CFG_RESET;
      end else if (wr_i && addr_i == lpm_pkg::CFG_OFS) begin
         cfg_reg <= wdata_i;
      end else if (cmd_wr && wdata_i[lpm_pkg::CMD_SUSP_BIT] && seq_reg == LPM_SEQ_IDLE) begin
         cfg_reg[lpm_pkg::CFG_DIV_LSB +: 3] <= lpm_pkg::SYSTEM_CLOCK_DIVIDER_FIELD_DIV1;
         cfg_reg[lpm_pkg::CFG_T3X8_BIT]     <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         seq_reg      <= LPM_SEQ_IDLE;
         gap_reg      <= '0;
         bus.power_control_register_wr  <= 1'b0;
         bus.osc_wr   <= 1'b0;
         bus.wdata    <= '0;
         bus.instr_done <= 1'b0;
      end else begin
         bus.power_control_register_wr    <= 1'b0;
         bus.osc_wr     <= 1'b0;
         bus.instr_done <= 1'b0;
         case (seq_reg)
            LPM_SEQ_IDLE: begin
               if (cmd_wr && cmd_any) begin
                  bus.power_control_register_wr <= !wdata_i[lpm_pkg::CMD_SUSP_BIT];
                  bus.osc_wr  <= wdata_i[lpm_pkg::CMD_SUSP_BIT];
                  bus.wdata   <= wdata_i[lpm_pkg::CMD_SUSP_BIT] ?
                                 (bus.osc_rdata | (8'h01 << lpm_pkg::OSC_SUSPEND_BIT)) :
                                 {6'h00, wdata_i[lpm_pkg::CMD_STOP_BIT],
                                  wdata_i[lpm_pkg::CMD_IDLE_BIT]};
                  gap_reg     <= 2'(lpm_pkg::SET_GAP_CYCLES - 1);
                  seq_reg     <= LPM_SEQ_GAP;
               end
            end
            LPM_SEQ_GAP: begin
               // setting instruction finishes only after a two-cycle follow-on
               if (gap_reg == '0) begin
                  bus.instr_done <= 1'b1;
                  seq_reg        <= LPM_SEQ_DONE;
               end else begin
                  gap_reg <= gap_reg - 2'h1;
               end
            end
            LPM_SEQ_DONE: begin
               if (!bus.cpu_halt || bus.restart) begin
                  seq_reg <= LPM_SEQ_IDLE;
               end
            end
            default: begin
               seq_reg <= LPM_SEQ_IDLE;
            end
         endcase
      end
   end

   always_comb begin
      bus.system_clock_divider_field      = cfg_reg[lpm_pkg::CFG_DIV_LSB +: 3];
      bus.wdt_en      = cfg_reg[lpm_pkg::CFG_WDT_BIT];
      bus.mcd_en      = cfg_reg[lpm_pkg::CFG_MCD_BIT];
      bus.cmp_wake_en = cfg_reg[lpm_pkg::CFG_CMP_BIT];
      bus.t3_ext8     = cfg_reg[lpm_pkg::CFG_T3X8_BIT];
      bus.irq_req     = irq_i;
      busy_o          = (seq_reg != LPM_SEQ_IDLE);
   end

   // ****************************************
   // read port
   // ****************************************
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= '0;
      end else if (rd_i) begin
         case (addr_i)
            lpm_pkg::CMD_OFS:  rdata_o <= bus.power_control_register_rdata;
            lpm_pkg::CFG_OFS:  rdata_o <= cfg_reg;
            lpm_pkg::STAT_OFS: rdata_o <= {5'h00, bus.cpu_halt, bus.mode};
            default:           rdata_o <= '0;
         endcase
      end else begin
         rdata_o <= '0;
      end
   end

endmodule // lpm_core

/* bench/lpm_props.sv */
// lpm_props: concurrent checks on the link between the core end and the controller end
// assumes it is instantiated beside the lpm_if instance, signals passed by name
`timescale 1ns/1ps
module lpm_props (
   input  wire logic               clk_i,        // system clock
   input  wire logic               rst_n_i,      // async reset, active low
   input  wire logic               instr_done,   // setting instruction done
   input  wire logic               irq_req,      // enabled interrupt pending
   input  wire logic [7:0]         power_control_register_rdata,   // power control read-back
   input  wire logic [7:0]         osc_rdata,    // oscillator control read-back
   input  wire logic [2:0]         system_clock_divider_field,       // clock divider field
   input  wire logic               t3_ext8,      // timer 3 on external / 8
   input  wire logic               cpu_halt,     // core halted
   input  wire logic               wake_irq,     // interrupt wake pulse
   input  wire logic               resume,       // resume pulse
   input  wire logic               restart,      // restart pulse
   input  wire logic [15:0]        restart_addr, // fetch address after restart
   input  wire lpm_pkg::lpm_mode_t mode          // current power mode
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   // ****************************************
   // checks
   // ****************************************
   sel_bits_zero_a: assert property (power_control_register_rdata[1:0] == 2'b00)
      else $error("select bits read back nonzero");
   halt_tracks_mode_a: assert property (cpu_halt == (mode != lpm_pkg::LPM_MODE_RUN))
      else $error("halt does not follow mode");
   entry_after_done_a: assert property (($past(mode) == lpm_pkg::LPM_MODE_RUN && mode != lpm_pkg::LPM_MODE_RUN) |-> $past(instr_done))
      else $error("mode entered before instruction done");
   idle_irq_wake_a: assert property ((mode == lpm_pkg::LPM_MODE_IDLE && irq_req) |=> (mode == lpm_pkg::LPM_MODE_RUN) ##[0:1] wake_irq)
      else $error("interrupt did not end idle");
   stop_reset_only_a: assert property (($past(mode) == lpm_pkg::LPM_MODE_STOP && mode != lpm_pkg::LPM_MODE_STOP) |-> ##[0:1] restart)
      else $error("stop left without reset");
   restart_vector_a: assert property (restart |-> restart_addr == 16'h0000)
      else $error("restart address not zero");
   susp_setup_a: assert property (mode == lpm_pkg::LPM_MODE_SUSP |-> (system_clock_divider_field == 3'h0 && t3_ext8 && osc_rdata[5]))
      else $error("suspend entered with wrong setup");
   susp_resume_a: assert property (($past(mode) == lpm_pkg::LPM_MODE_SUSP && mode == lpm_pkg::LPM_MODE_RUN) |-> ##[0:1] (resume || restart))
      else $error("suspend left without resume");
   resume_pulse_a: assert property (resume |=> !resume)
      else $error("resume longer than one cycle");
endmodule // lpm_props

/* bench/tb_low_power_mode_control.sv */
// tb_low_power_mode_control: both ends joined by lpm_if, driven through the register port
// assumes the 10 MHz clock and a shortened watchdog count
`timescale 1ns/1ps
module tb_low_power_mode_control;
   logic       clk_i   = 1'b0;
   logic       rst_n_i = 1'b0;
   logic [3:0] addr    = 4'h0;
   logic [7:0] wdata   = 8'h00;
   logic       wr      = 1'b0;
   logic       rd      = 1'b0;
   logic       irq     = 1'b0;
   logic       ext_rst = 1'b0;
   logic       kick    = 1'b0;
   logic [3:0] src     = 4'h0; // t3 overflow, comparator low, cap sense, port match
   logic [7:0] rdata;
   logic       busy, hfosc, dig_en, pm_en, t3_run;
   int         num_errors = 0;
   int         samples_checked = 0;
   int         n_resume = 0;
   int         n_restart = 0;
   int         n_wake = 0;
   int         dt, r0;

   lpm_if lnk ();
   lpm_core lpm_core_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(lnk), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_i(irq), .busy_o(busy));
   lpm_ctrl #(.WDT_CYCLES(20)) lpm_ctrl_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(lnk),
      .ext_rst_i(ext_rst), .wdt_kick_i(kick), .port_match_i(src[3]), .t3_ovf_i(src[0]),
      .cmp_low_i(src[1]), .cs_gt_i(src[2]), .hfosc_run_o(hfosc), .dig_clk_en_o(dig_en),
      .port_match_en_o(pm_en), .t3_run_o(t3_run));
   lpm_props lpm_props_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .instr_done(lnk.instr_done),
      .irq_req(lnk.irq_req), .power_control_register_rdata(lnk.power_control_register_rdata), .osc_rdata(lnk.osc_rdata),
      .system_clock_divider_field(lnk.system_clock_divider_field), .t3_ext8(lnk.t3_ext8), .cpu_halt(lnk.cpu_halt),
      .wake_irq(lnk.wake_irq), .resume(lnk.resume), .restart(lnk.restart),
      .restart_addr(lnk.restart_addr), .mode(lnk.mode));

   always #50 clk_i = ~clk_i;

   always @(posedge clk_i) begin
      if (lnk.resume === 1'b1) n_resume++;
      if (lnk.restart === 1'b1) n_restart++;
      if (lnk.wake_irq === 1'b1) n_wake++;
   end

   // ****************************************
   // access tasks
   // ****************************************
   task automatic stop_test;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1 chk(what, 16'(rdata), 16'(exp));
   endtask
   task automatic cmd(input logic [7:0] d);
      for (int i = 0; i < 20 && busy !== 1'b0; i++) @(posedge clk_i);
      wr_reg(lpm_pkg::CMD_OFS, d);
   endtask
   task automatic wait_mode(input lpm_pkg::lpm_mode_t m, input int lim);
      dt = 0;
      while (lnk.mode !== m && dt < lim) begin
         @(posedge clk_i);
         #1 dt++;
      end
      chk("mode", 16'(lnk.mode), 16'(m));
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd_chk("stat", lpm_pkg::STAT_OFS, 8'h00);
      rd_chk("unmapped", 4'hC, 8'h00);
      cmd(8'h01);
      #1 chk("busy", 16'(busy), 16'h0001);
      wait_mode(lpm_pkg::LPM_MODE_IDLE, 10);
      rd_chk("stat idle", lpm_pkg::STAT_OFS, 8'h05);
      chk("idle clocks", 16'({hfosc, dig_en}), 16'h0003);
      rd_chk("cmd rb", lpm_pkg::CMD_OFS, 8'h00);
      @(posedge clk_i) irq <= 1'b1;
      wait_mode(lpm_pkg::LPM_MODE_RUN, 4);
      @(posedge clk_i) irq <= 1'b0;
      #1 chk("wake", 16'(n_wake), 16'h0001);
      cmd(8'h02);
      wait_mode(lpm_pkg::LPM_MODE_STOP, 10);
      // clock gates follow the mode one edge later
      @(posedge clk_i);
      #1 chk("stop clocks", 16'({hfosc, dig_en}), 16'h0000);
      @(posedge clk_i) irq <= 1'b1;
      src <= 4'b1111;
      repeat (5) @(posedge clk_i);
      irq <= 1'b0;
      src <= 4'b0000;
      wait_mode(lpm_pkg::LPM_MODE_STOP, 0);
      @(posedge clk_i) ext_rst <= 1'b1;
      @(posedge clk_i) ext_rst <= 1'b0;
      wait_mode(lpm_pkg::LPM_MODE_RUN, 4);
      repeat (2) @(posedge clk_i);
      #1 chk("restart", 16'(n_restart), 16'h0001);
      chk("vector", lnk.restart_addr, 16'h0000);
      wr_reg(lpm_pkg::CFG_OFS, 8'h02);
      cmd(8'h02);
      wait_mode(lpm_pkg::LPM_MODE_STOP, 10);
      wait_mode(lpm_pkg::LPM_MODE_RUN, 1100);
      chk("mcd span", 16'(dt > 994 && dt < 1006), 16'h0001);
      wr_reg(lpm_pkg::CFG_OFS, 8'h01);
      @(posedge clk_i) kick <= 1'b1;
      @(posedge clk_i) kick <= 1'b0;
      cmd(8'h01);
      wait_mode(lpm_pkg::LPM_MODE_IDLE, 10);
      wait_mode(lpm_pkg::LPM_MODE_RUN, 60);
      wr_reg(lpm_pkg::CFG_OFS, 8'h04);
      #1 chk("restart", 16'(n_restart), 16'h0003);
      r0 = n_resume;
      for (int k = 0; k < 4; k++) begin
         // pending pulses before entry, and a port match level held for the last pass
         @(posedge clk_i) src <= (k == 3) ? 4'b1101 : 4'b0101;
         @(posedge clk_i) src[0] <= 1'b0;
         src[2] <= 1'b0;
         cmd(8'h04);
         // the held port match must still see suspend entered before it wakes
         wait_mode(lpm_pkg::LPM_MODE_SUSP, 10);
         if (k < 3) begin
            @(posedge clk_i);
            #1 chk("susp gates", 16'({hfosc, dig_en, pm_en, t3_run}), 16'h0003);
            rd_chk("stat susp", lpm_pkg::STAT_OFS, 8'h07);
            wait_mode(lpm_pkg::LPM_MODE_SUSP, 0);
            @(posedge clk_i) src[k] <= 1'b1;
            @(posedge clk_i) src[k] <= 1'b0;
         end
         wait_mode(lpm_pkg::LPM_MODE_RUN, 6);
         @(posedge clk_i) src[3] <= 1'b0;
         repeat (2) @(posedge clk_i);
         #1 chk("resume", 16'(n_resume - r0), 16'(k + 1));
      end
      stop_test;
   end

   // about twelve hundred cycles are needed; cut a hang well beyond that
   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      stop_test;
   end
endmodule // tb_low_power_mode_control
